// *** logic/pca_mode_pkg.sv ***
// Shared types, offsets and helpers for the counter-array mode control
package pca_mode_pkg;

  // Register offsets on the special-function register bus
  localparam logic [7:0] ADDR_MODE0 = 8'hDA;
  localparam logic [7:0] ADDR_MODE1 = 8'hDB;
  localparam logic [7:0] ADDR_MODE2 = 8'hDC;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
  localparam logic [15:0] CAPTURE_RESET = 16'h0000;
  localparam int BASE_CYCLE_BITS = 8;
  localparam int WATCHED_CHANNEL = 2;

  // Bit 7 down to bit 0 of each mode register
  typedef struct packed {
    logic wide_modulation_select;
    logic comparator_enable;
    logic rising_capture_enable;
    logic falling_capture_enable;
    logic match_flag_enable;
    logic toggle_enable;
    logic pulse_width_enable;
    logic channel_interrupt_enable;
  } mode_t;

  typedef enum logic [2:0] {
    CH_OFF = 3'b000,
    CH_CAPTURE = 3'b001,
    CH_COMPARE = 3'b010,
    CH_PWM = 3'b011,
    CH_FREQ = 3'b100
  } chan_mode_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef struct packed {
    logic tick;
    logic [15:0] count;
  } counter_t;

  typedef struct packed {
    logic pin_out;
    logic pin_oe;
    logic flag_set;
    logic irq_request;
  } chan_out_t;

  // Waveform modes win over capture and compare
  function automatic chan_mode_t decode_mode(input mode_t m);
    if (m.pulse_width_enable && m.toggle_enable) begin
      return CH_FREQ;
    end else if (m.pulse_width_enable) begin
      return CH_PWM;
    end else if (m.rising_capture_enable || m.falling_capture_enable) begin
      return CH_CAPTURE;
    end else if (m.comparator_enable) begin
      return CH_COMPARE;
    end
    return CH_OFF;
  endfunction

  // Mask of counter bits in one modulation cycle
  function automatic logic [15:0] cycle_mask(input logic wide, input logic [2:0] sel);
    logic [4:0] bits;
    bits = wide ? 5'h10 : 5'(BASE_CYCLE_BITS + int'(sel));
    return 16'((32'h1 << bits) - 32'h1);
  endfunction

endpackage

// *** logic/pca_channel.sv ***
// One capture/compare channel driven by its mode byte
`timescale 1ns/100ps
module pca_channel (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Configuration
  input wire pca_mode_pkg::mode_t mode,
  input wire logic [2:0] cycle_length_select,
  // Counter and compare value
  input wire pca_mode_pkg::counter_t ctr,
  input wire logic [15:0] compare_value,
  input wire logic capture_compare_flag,
  // Channel pin
  input wire logic channel_pin_in,
  output pca_mode_pkg::chan_out_t chan,
  output logic [15:0] captured_value
);
  import pca_mode_pkg::*;

  typedef struct packed {
    logic pin_prev;
    logic pin_level;
    logic flag_set;
    logic [15:0] captured;
  } chan_state_t;

  chan_state_t state_reg;
  chan_state_t state_next;
  chan_mode_t cm;
  logic [15:0] mask;
  logic hit;
  logic low_hit;
  logic rise;
  logic fall;

  always_comb begin
    cm = decode_mode(mode);
    mask = cycle_mask(mode.wide_modulation_select, cycle_length_select);
    hit = ctr.tick && ((ctr.count & mask) == (compare_value & mask));
    low_hit = ctr.tick && (ctr.count[7:0] == compare_value[7:0]);
    rise = channel_pin_in && !state_reg.pin_prev;
    fall = !channel_pin_in && state_reg.pin_prev;
    state_next = state_reg;
    state_next.flag_set = 1'b0;
    state_next.pin_prev = channel_pin_in;
    unique case (cm)
      CH_CAPTURE: begin
        if ((mode.rising_capture_enable && rise) || (mode.falling_capture_enable && fall)) begin
          state_next.captured = ctr.count;
          state_next.flag_set = 1'b1;
        end
      end
      CH_COMPARE: begin
        // match flag and toggle
        // Whole counter must match; the cycle mask is for modulation only
        if (ctr.tick && ctr.count == compare_value) begin
          state_next.flag_set = mode.match_flag_enable;
          if (mode.toggle_enable) begin
            state_next.pin_level = !state_reg.pin_level;
          end
        end
      end
      CH_PWM: begin
        // pin high while masked count is at or above compare
        if (ctr.tick) begin
          state_next.pin_level = (ctr.count & mask) >= (compare_value & mask);
        end
        state_next.flag_set = hit && mode.match_flag_enable;
      end
      CH_FREQ: begin
        if (low_hit) begin
          state_next.pin_level = !state_reg.pin_level;
        end
      end
      CH_OFF: begin
        state_next.pin_level = state_reg.pin_level;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= '{pin_prev: 1'b0, pin_level: 1'b0, flag_set: 1'b0, captured: CAPTURE_RESET};
    end else begin
      state_reg <= state_next;
    end
  end

  // Pin is driven only in modes that shape it
  assign chan = '{
    pin_out: state_reg.pin_level,
    pin_oe: (cm == CH_PWM) || (cm == CH_FREQ) || (cm == CH_COMPARE && mode.toggle_enable),
    flag_set: state_reg.flag_set,
    irq_request: capture_compare_flag && mode.channel_interrupt_enable
  };
  assign captured_value = state_reg.captured;

endmodule // pca_channel

// *** logic/pca_mode_control.sv ***
// Mode registers and channels of the programmable counter array
`timescale 1ns/100ps
module pca_mode_control #(
  parameter int NUM_CHANNELS = 3
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register bus
  input wire pca_mode_pkg::sfr_req_t sfr,
  output logic [7:0] sfr_rdata,
  output logic write_refused,
  // Shared controls from neighbouring registers
  input wire logic watchdog_enable,
  input wire logic [2:0] cycle_length_select,
  input wire logic reload_view_select,
  output logic value_to_reload,
  // Counter and per-channel values
  input wire pca_mode_pkg::counter_t ctr,
  input wire logic [NUM_CHANNELS-1:0][15:0] compare_value,
  input wire logic [NUM_CHANNELS-1:0] capture_compare_flag,
  output logic [NUM_CHANNELS-1:0][15:0] captured_value,
  // Channel pins
  input wire logic [NUM_CHANNELS-1:0] channel_pin_in,
  output pca_mode_pkg::chan_out_t [NUM_CHANNELS-1:0] chan
);
  import pca_mode_pkg::*;

  typedef struct packed {
    mode_t [NUM_CHANNELS-1:0] mode;
    logic [7:0] rdata;
    logic refused;
    logic reload_view;
  } ctrl_state_t;

  ctrl_state_t state_reg;
  ctrl_state_t state_next;

  function automatic logic [7:0] mode_addr(input int idx);
    unique case (idx)
      0: return ADDR_MODE0;
      1: return ADDR_MODE1;
      default: return ADDR_MODE2;
    endcase
  endfunction

  always_comb begin
    state_next = state_reg;
    state_next.refused = 1'b0;
    state_next.rdata = RDATA_UNMAPPED;
    state_next.reload_view = reload_view_select;
    for (int i = 0; i < NUM_CHANNELS; i++) begin
      if (sfr.rd && sfr.addr == mode_addr(i)) begin
        state_next.rdata = state_reg.mode[i];
      end
      if (sfr.wr && sfr.addr == mode_addr(i)) begin
        if (i == WATCHED_CHANNEL && watchdog_enable) begin
          state_next.refused = 1'b1;
        end else begin
          state_next.mode[i] = mode_t'(sfr.wdata);
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= '{mode: '{default: mode_t'(MODE_RESET)}, rdata: RDATA_UNMAPPED, refused: 1'b0, reload_view: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign sfr_rdata = state_reg.rdata;
  assign write_refused = state_reg.refused;
  assign value_to_reload = state_reg.reload_view;

  for (genvar g = 0; g < NUM_CHANNELS; g++) begin : g_chan
    pca_channel u_chan (
      .sys_clk(sys_clk),
      .rst(rst),
      .mode(state_reg.mode[g]),
      .cycle_length_select(cycle_length_select),
      .ctr(ctr),
      .compare_value(compare_value[g]),
      .capture_compare_flag(capture_compare_flag[g]),
      .channel_pin_in(channel_pin_in[g]),
      .chan(chan[g]),
      .captured_value(captured_value[g])
    );
  end

  // Checks on channels 0 and 2 and the register file
  mode_t m0;
  assign m0 = state_reg.mode[0];
  mode_t m2;
  assign m2 = state_reg.mode[WATCHED_CHANNEL];

  property p_pwm_drives;
    @(posedge sys_clk) disable iff (rst)
      (m0.pulse_width_enable && !m0.toggle_enable) |-> chan[0].pin_oe;
  endproperty
  a_pwm_drives: assert property (p_pwm_drives) else $error("pwm channel not driving pin");

  property p_wide_cycle;
    @(posedge sys_clk) disable iff (rst)
      (m0.pulse_width_enable && !m0.toggle_enable && m0.wide_modulation_select && !sfr.wr && ctr.tick)
        |=> (chan[0].pin_out == ($past(ctr.count) >= $past(compare_value[0])));
  endproperty
  a_wide_cycle: assert property (p_wide_cycle) else $error("16-bit pwm level wrong");

  property p_freq_toggle;
    @(posedge sys_clk) disable iff (rst)
      (m0.pulse_width_enable && m0.toggle_enable && !sfr.wr && ctr.tick
        && ctr.count[7:0] == compare_value[0][7:0]) |=> (chan[0].pin_out != $past(chan[0].pin_out));
  endproperty
  a_freq_toggle: assert property (p_freq_toggle) else $error("frequency output did not toggle");

  property p_watchdog_lock;
    @(posedge sys_clk) disable iff (rst)
      (sfr.wr && sfr.addr == ADDR_MODE2 && watchdog_enable)
        |=> ($stable(state_reg.mode[WATCHED_CHANNEL]) && write_refused);
  endproperty
  a_watchdog_lock: assert property (p_watchdog_lock) else $error("locked mode register changed");

  property p_mode_write;
    @(posedge sys_clk) disable iff (rst)
      (sfr.wr && sfr.addr == ADDR_MODE0) ##1 (sfr.rd && sfr.addr == ADDR_MODE0 && !sfr.wr)
        |=> (sfr_rdata == $past(sfr.wdata, 2));
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode readback mismatch");

  property p_reset_clear;
    @(posedge sys_clk) rst |=> (state_reg.mode[0] == MODE_RESET && state_reg.mode[2] == MODE_RESET);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("mode bits not cleared by reset");

  property p_short_cycle;
    @(posedge sys_clk) disable iff (rst)
      (m0.pulse_width_enable && !m0.toggle_enable && !m0.wide_modulation_select && !sfr.wr
        && cycle_length_select == 3'b000 && ctr.tick)
        |=> (chan[0].pin_out == ($past(ctr.count[7:0]) >= $past(compare_value[0][7:0])));
  endproperty
  a_short_cycle: assert property (p_short_cycle) else $error("8-bit pwm level wrong");

  property p_reload_view;
    @(posedge sys_clk) disable iff (rst)
      reload_view_select ##1 reload_view_select |-> value_to_reload;
  endproperty
  a_reload_view: assert property (p_reload_view) else $error("value target not steered");

  property p_reload_clear;
    @(posedge sys_clk) disable iff (rst)
      !reload_view_select |=> !value_to_reload;
  endproperty
  a_reload_clear: assert property (p_reload_clear) else $error("value target stuck on reload");

  property p_unmapped_read;
    @(posedge sys_clk) disable iff (rst)
      (sfr.rd && sfr.addr != ADDR_MODE0 && sfr.addr != ADDR_MODE1 && sfr.addr != ADDR_MODE2)
        |=> (sfr_rdata == RDATA_UNMAPPED);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

  property p_read_idle;
    @(posedge sys_clk) disable iff (rst)
      !sfr.rd |=> (sfr_rdata == RDATA_UNMAPPED);
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data held past its cycle");

  property p_refused_cause;
    @(posedge sys_clk) disable iff (rst)
      write_refused |-> $past(sfr.wr && sfr.addr == ADDR_MODE2 && watchdog_enable);
  endproperty
  a_refused_cause: assert property (p_refused_cause) else $error("refusal without locked write");

  property p_unlocked_write;
    @(posedge sys_clk) disable iff (rst)
      (sfr.wr && sfr.addr == ADDR_MODE2 && !watchdog_enable)
        |=> (state_reg.mode[WATCHED_CHANNEL] == $past(sfr.wdata) && !write_refused);
  endproperty
  a_unlocked_write: assert property (p_unlocked_write) else $error("unlocked mode write lost");

  property p_locked_drive;
    @(posedge sys_clk) disable iff (rst)
      m2.pulse_width_enable |-> chan[WATCHED_CHANNEL].pin_oe;
  endproperty
  a_locked_drive: assert property (p_locked_drive) else $error("channel 2 waveform not driven");

  property p_freq_hold;
    @(posedge sys_clk) disable iff (rst)
      (m0.pulse_width_enable && m0.toggle_enable
        && !(ctr.tick && ctr.count[7:0] == compare_value[0][7:0]))
        |=> $stable(chan[0].pin_out);
  endproperty
  a_freq_hold: assert property (p_freq_hold) else $error("frequency output moved without match");

  property p_long_cycle;
    @(posedge sys_clk) disable iff (rst)
      (m0.pulse_width_enable && !m0.toggle_enable && !m0.wide_modulation_select
        && cycle_length_select == 3'h7 && ctr.tick)
        |=> (chan[0].pin_out == ($past(ctr.count[14:0]) >= $past(compare_value[0][14:0])));
  endproperty
  a_long_cycle: assert property (p_long_cycle) else $error("15-bit pwm level wrong");

  property p_compare_toggle;
    @(posedge sys_clk) disable iff (rst)
      (m0.comparator_enable && m0.toggle_enable && !m0.pulse_width_enable && !m0.rising_capture_enable
        && !m0.falling_capture_enable && ctr.tick && ctr.count == compare_value[0])
        |=> (chan[0].pin_out != $past(chan[0].pin_out) && chan[0].flag_set == $past(m0.match_flag_enable));
  endproperty
  a_compare_toggle: assert property (p_compare_toggle) else $error("compare match not acted on");

  property p_idle_released;
    @(posedge sys_clk) disable iff (rst)
      (m0 == MODE_RESET) |-> !chan[0].pin_oe;
  endproperty
  a_idle_released: assert property (p_idle_released) else $error("idle channel drives its pin");

  c_pwm: cover property (@(posedge sys_clk) disable iff (rst) m0.pulse_width_enable && chan[0].pin_out);
  c_freq: cover property (@(posedge sys_clk) disable iff (rst) m0.pulse_width_enable && m0.toggle_enable);
  c_refused: cover property (@(posedge sys_clk) disable iff (rst) write_refused);
  c_capture: cover property (@(posedge sys_clk) disable iff (rst) chan[0].flag_set);
  c_compare: cover property (@(posedge sys_clk) disable iff (rst)
    m0.comparator_enable && !m0.pulse_width_enable && chan[0].flag_set);

endmodule // pca_mode_control

// *** bench/pin_partner.sv ***
// External pins of the three channels, seen from the board side
`timescale 1ns/100ps
module pin_partner (
  // Module side
  input wire logic [2:0] pin_out,
  input wire logic [2:0] pin_oe,
  // Board side
  input wire logic [2:0] ext_level,
  output logic [2:0] pin_in
);
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // pin_partner

// *** bench/pca_mode_control_tb.sv ***
// Self-checking bench for the counter-array mode control
`timescale 1ns/100ps
module pca_mode_control_tb;
  import pca_mode_pkg::*;
  logic sys_clk, rst, watchdog_enable, reload_view_select, value_to_reload, write_refused, v;
  sfr_req_t sfr;
  logic [7:0] sfr_rdata;
  logic [2:0] cycle_length_select, capture_compare_flag, channel_pin_in, ext_level, pin_out, pin_oe;
  counter_t ctr;
  logic [2:0][15:0] compare_value, captured_value;
  chan_out_t [2:0] chan;
  int err_total = 0;
  int total_checks = 0;

  pca_mode_control #(.NUM_CHANNELS(3)) dut (.sys_clk(sys_clk), .rst(rst), .sfr(sfr), .sfr_rdata(sfr_rdata),
    .write_refused(write_refused), .watchdog_enable(watchdog_enable), .cycle_length_select(cycle_length_select),
    .reload_view_select(reload_view_select), .value_to_reload(value_to_reload), .ctr(ctr),
    .compare_value(compare_value), .capture_compare_flag(capture_compare_flag), .captured_value(captured_value),
    .channel_pin_in(channel_pin_in), .chan(chan));
  pin_partner partner (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level), .pin_in(channel_pin_in));

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pin_out[i] = chan[i].pin_out;
      pin_oe[i] = chan[i].pin_oe;
    end
  end

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sfr <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    sfr <= '0;
    #1;
  endtask

  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    sfr <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge sys_clk);
    sfr <= '0;
    #1;
    chk("sfr_rdata", 16'(sfr_rdata), 16'(exp));
  endtask

  // Write then read back with no idle cycle between
  task wr_rd(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sfr <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    sfr <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge sys_clk);
    sfr <= '0;
    #1;
    chk("sfr_rdata", 16'(sfr_rdata), 16'(d));
  endtask

  task tick(input logic [15:0] c);
    @(posedge sys_clk);
    ctr <= '{tick: 1'b1, count: c};
    @(posedge sys_clk);
    ctr.tick <= 1'b0;
    #1;
  endtask

  task t_regs;
    rd(ADDR_MODE0, MODE_RESET);
    rd(ADDR_MODE1, MODE_RESET);
    rd(ADDR_MODE2, MODE_RESET);
    wr(ADDR_MODE1, 8'hFD);
    rd(ADDR_MODE1, 8'hFD);
    wr(8'h50, 8'hFF);
    rd(8'h50, RDATA_UNMAPPED);
    wr(ADDR_MODE1, 8'h00);
    wr_rd(ADDR_MODE0, 8'hA5);
    wr(ADDR_MODE0, 8'h00);
  endtask

  task t_lock;
    @(posedge sys_clk);
    watchdog_enable <= 1'b1;
    wr(ADDR_MODE2, 8'h42);
    chk("write_refused", 16'(write_refused), 16'h0001);
    rd(ADDR_MODE2, 8'h00);
    @(posedge sys_clk);
    watchdog_enable <= 1'b0;
    wr(ADDR_MODE2, 8'h42);
    chk("write_refused", 16'(write_refused), 16'h0000);
    rd(ADDR_MODE2, 8'h42);
    wr(ADDR_MODE2, 8'h00);
  endtask

  task t_pwm;
    @(posedge sys_clk);
    compare_value[0] <= 16'h0080;
    wr(ADDR_MODE0, 8'h02);
    chk("pin_oe0", 16'(pin_oe[0]), 16'h0001);
    tick(16'h0081);
    chk("pin_out0", 16'(pin_out[0]), 16'h0001);
    tick(16'h007F);
    chk("pin_out0", 16'(pin_out[0]), 16'h0000);
    tick(16'h0180);
    chk("pin_out0", 16'(pin_out[0]), 16'h0001);
    @(posedge sys_clk);
    cycle_length_select <= 3'h7;
    compare_value[0] <= 16'h4000;
    tick(16'h3FFF);
    chk("pin_out0", 16'(pin_out[0]), 16'h0000);
    tick(16'hC000);
    chk("pin_out0", 16'(pin_out[0]), 16'h0001);
    @(posedge sys_clk);
    compare_value[0] <= 16'h8000;
    wr(ADDR_MODE0, 8'h82);
    tick(16'h7FFF);
    chk("pin_out0", 16'(pin_out[0]), 16'h0000);
    tick(16'h8000);
    chk("pin_out0", 16'(pin_out[0]), 16'h0001);
  endtask

  task t_freq;
    @(posedge sys_clk);
    compare_value[0] <= 16'h0012;
    wr(ADDR_MODE0, 8'h06);
    tick(16'h0012);
    chk("pin_out0", 16'(pin_out[0]), 16'h0000);
    v = pin_out[0];
    tick(16'h0013);
    chk("pin_out0", 16'(pin_out[0]), 16'(v));
    tick(16'h0112);
    chk("pin_out0", 16'(pin_out[0]), 16'(!v));
  endtask

  // Pin enters high from the frequency scenario
  task t_compare;
    @(posedge sys_clk);
    compare_value[0] <= 16'h0234;
    wr(ADDR_MODE0, 8'h4C);
    chk("pin_oe0", 16'(pin_oe[0]), 16'h0001);
    tick(16'h8234);
    chk("flag_set0", 16'(chan[0].flag_set), 16'h0000);
    chk("pin_out0", 16'(pin_out[0]), 16'h0001);
    tick(16'h0234);
    chk("flag_set0", 16'(chan[0].flag_set), 16'h0001);
    chk("pin_out0", 16'(pin_out[0]), 16'h0000);
    wr(ADDR_MODE0, 8'h00);
    chk("pin_oe0", 16'(pin_oe[0]), 16'h0000);
  endtask

  task t_capture;
    @(posedge sys_clk);
    capture_compare_flag[1] <= 1'b1;
    wr(ADDR_MODE1, 8'h21);
    chk("irq1", 16'(chan[1].irq_request), 16'h0001);
    @(posedge sys_clk);
    ctr.count <= 16'h1234;
    @(posedge sys_clk);
    ext_level[1] <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk("captured1", captured_value[1], 16'h1234);
    chk("flag_set1", 16'(chan[1].flag_set), 16'h0001);
    @(posedge sys_clk);
    ctr.count <= 16'h5678;
    @(posedge sys_clk);
    ext_level[1] <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk("captured1", captured_value[1], 16'h1234);
    chk("value_to_reload", 16'(value_to_reload), 16'h0000);
    @(posedge sys_clk);
    reload_view_select <= 1'b1;
    @(posedge sys_clk);
    @(posedge sys_clk);
    #1;
    chk("value_to_reload", 16'(value_to_reload), 16'h0001);
  endtask

  task close_out;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Whole run is about a hundred cycles
  initial begin
    #200000;
    err_total++;
    close_out();
  end

  initial begin
    rst = 1'b1;
    sfr = '0;
    watchdog_enable = 1'b0;
    cycle_length_select = 3'h0;
    reload_view_select = 1'b0;
    ctr = '0;
    compare_value = '0;
    capture_compare_flag = 3'h0;
    ext_level = 3'h0;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs();
    t_lock();
    t_pwm();
    t_freq();
    t_compare();
    t_capture();
    close_out();
  end
endmodule // pca_mode_control_tb
